/* File: sim/i2c_command_port_master_monitor.sv */
// pin-level checks on the command-port i2c master
`timescale 1ns/100ps
`default_nettype none
module i2c_command_port_master_monitor (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // avalon-mm slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // i2c and general output
    input wire logic scl_out,
    input wire logic sda_oe_out,
    input wire logic [7:0] general_output_byte_out
);
    import i2c_cmd_pkg::*;
    // --------------------
    // properties
    // --------------------
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic gpo_wr;
    assign gpo_wr = avs_write_in && avs_address_in == ADDR_GPO;
    sequence one_wait;
        avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence
    sequence start_seen;
        $rose(sda_oe_out) && scl_out;
    endsequence
    chk_read_wait: assert property (
        $rose(avs_read_in) |-> one_wait) else $error("read wait wrong");
    chk_write_nowait: assert property (
        avs_write_in && avs_address_in != ADDR_REQUEST |->
        !avs_waitrequest_out) else $error("register write stalled");
    chk_gpo_load: assert property (
        gpo_wr && avs_byteenable_in[0] |=> {24'h0, general_output_byte_out}
        == ($past(avs_writedata_in) & 32'hff)) else $error("gpo not loaded");
    chk_gpo_hold: assert property (
        !gpo_wr |=> $stable(general_output_byte_out)) else $error("gpo moved");
    chk_gpo_back: assert property (
        avs_read_in && avs_address_in == ADDR_GPO && !avs_waitrequest_out |->
        avs_readdata_out[7:0] == general_output_byte_out)
        else $error("gpo readback wrong");
    chk_hole_zero: assert property (
        avs_read_in && avs_address_in[1:0] != 2'h0 && !avs_waitrequest_out
        |-> avs_readdata_out == 32'h0) else $error("hole read not zero");
    chk_scl_high: assert property (
        $rose(scl_out) |=> scl_out) else $error("scl high too short");
    chk_start_low: assert property (
        start_seen |-> ##[1:1000] !scl_out) else $error("no scl low after start");
endmodule : i2c_command_port_master_monitor
`default_nettype wire

/* File: sim/i2c_command_port_master_tb_top.sv */
// self-checking bench for the command-port i2c master
`timescale 1ns/100ps
`default_nettype none
module i2c_command_port_master_tb_top;
    import i2c_cmd_pkg::*;
    // --------------------
    // design and far side
    // --------------------
    logic core_clk_in, rst_in, avs_read_in, avs_write_in, pull, sda;
    logic [3:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic avs_waitrequest_out, scl_out, sda_out, sda_oe_out;
    logic [7:0] general_output_byte_out;
    int err_count, tests_run;
    // request word, expected response
    logic [63:0] rows [14] = '{64'h08010000_08010000,
        64'h01a0337e_01a0337e, 64'h02a033ff_02a0335c, 64'h10ffffff_10000000,
        64'h12a1abcd_12a10000, 64'h14ffffff_145c0000, 64'h15000000_155c0000,
        64'h10000000_10000000, 64'h12a0ffff_12a00000, 64'h13330000_13330000,
        64'h10000000_10000000, 64'h11abcdef_11000000, 64'h77123456_deadbeef,
        64'h01b03344_deadcafe};
    assign sda = sda_oe_out ? sda_out : !pull;
    i2c_command_port_master i_i2c_command_port_master (.core_clk_in,
        .rst_in, .ce_in(1'b1), .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_byteenable_in(4'hf), .avs_readdata_out,
        .avs_waitrequest_out, .scl_out, .sda_in(sda), .sda_out, .sda_oe_out,
        .general_output_byte_out);
    i2c_target_model i_i2c_target_model (.scl_in(scl_out), .sda_in(sda),
        .pull_out(pull));
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] r);
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_address_in <= a;
        avs_writedata_in <= d;
        do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
        r = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : bus
    task automatic collect(output logic [31:0] r);
        r = 32'h0;
        while (r[STAT_RESP_BIT] !== 1'b1)
            bus(1'b0, ADDR_STATUS, 32'h0, r);
        bus(1'b0, ADDR_RESPONSE, 32'h0, r);
    endtask : collect
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = !core_clk_in;
    end
    initial begin
        #2000000;
        err_count++;
        results();
    end
    initial begin
        {err_count, tests_run} = 0;
        {rst_in, avs_read_in, avs_write_in} = 3'b100;
        avs_address_in = 4'h0;
        avs_writedata_in = 32'h0;
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        foreach (rows[i]) begin
            bus(1'b1, ADDR_REQUEST, rows[i][63:32], q);
            collect(q);
            check("resp", q, rows[i][31:0]);
        end
        rst_in <= 1'b1;
        @(posedge core_clk_in);
        rst_in <= 1'b0;
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        check("delay", {24'h0, q[15:8]}, {24'h0, DELAY_RESET});
        check("gpo", {24'h0, general_output_byte_out}, 32'h0);
        bus(1'b1, ADDR_GPO, 32'hffffffa5, q);
        bus(1'b1, 4'h2, 32'h0, q);
        bus(1'b0, 4'h2, 32'h0, q);
        check("hole", q, 32'h0);
        bus(1'b0, ADDR_GPO, 32'h0, q);
        check("gpo back", q, 32'ha5);
        bus(1'b0, ADDR_RESPONSE, 32'h0, q);
        check("empty resp", q, 32'h0);
        bus(1'b1, ADDR_REQUEST, 32'h77000000, q);
        bus(1'b1, ADDR_REQUEST, 32'h08020000, q);
        collect(q);
        check("first", q, RESP_UNKNOWN);
        collect(q);
        check("second", q, 32'h08020000);
        results();
    end
endmodule : i2c_command_port_master_tb_top
bind i2c_command_port_master i2c_command_port_master_monitor i_mon (
    .core_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .scl_out, .sda_oe_out, .general_output_byte_out);
`default_nettype wire

/* File: sim/i2c_target_model.sv */
// behavioural i2c target: acks its address, returns a fixed byte
`timescale 1ns/100ps
`default_nettype none
module i2c_target_model #(
    parameter logic [7:0] DEV = 8'ha0,
    parameter logic [7:0] RDATA = 8'h5c
) (
    // bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    output logic pull_out
);
    // --------------------
    // bit tracking
    // --------------------
    logic [7:0] sh;
    logic first = 1'b0;
    logic rd = 1'b0;
    logic sel = 1'b0;
    int cnt = 0;
    initial pull_out = 1'b0;
    // start or stop: sda moves while scl high
    always @(sda_in) begin
        if (scl_in) begin
            cnt = 0;
            first = !sda_in;
            pull_out = 1'b0;
        end
    end
    always @(posedge scl_in) begin
        if (cnt < 8)
            sh = {sh[6:0], sda_in};
        else if (rd && sda_in)
            sel = 1'b0;
        cnt = cnt + 1;
    end
    always @(negedge scl_in) begin
        if (cnt == 8) begin
            if (first) begin
                sel = sh[7:1] == DEV[7:1];
                rd = sh[0];
            end
            pull_out = sel && (first || !rd);
        end else if (cnt == 9) begin
            cnt = 0;
            first = 1'b0;
            pull_out = sel && rd && !RDATA[7];
        end else if (cnt > 0 && sel && rd && !first)
            pull_out = !RDATA[7 - cnt];
    end
endmodule : i2c_target_model
`default_nettype wire

/* File: verilog/i2c_bit_engine.sv */
// start, stop and byte steps on scl and sda, quarter-bit timed
`timescale 1ns/100ps
`default_nettype none

module i2c_bit_engine (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // step port
    i2c_op_if.engine op_port,
    // i2c pins
    output logic scl_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out
);
    import i2c_cmd_pkg::*;

    logic busy_r, busy_nxt;
    i2c_op_e op_r, op_nxt;
    logic [1:0] q_r, q_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic nack_r, nack_nxt;
    logic done_r, done_nxt;
    logic scl_r, scl_nxt;
    logic sda_low_r, sda_low_nxt;
    logic sda_meta_r, sda_s_r;
    logic is_byte;

    // --------------------
    // phase tables
    // --------------------
    function automatic logic phase_scl(input i2c_op_e op,
                                       input logic [1:0] q);
        if (op == OP_STOP) begin
            phase_scl = (q != 2'h0);
        end else begin
            phase_scl = (q == 2'h1) || (q == 2'h2);
        end
    endfunction : phase_scl

    function automatic logic phase_sda(input i2c_op_e op,
                                       input logic [1:0] q,
                                       input logic [3:0] bitn,
                                       input logic msb);
        phase_sda = 1'b0;
        case (op)
            OP_START: phase_sda = q[1];
            OP_STOP: phase_sda = !q[1];
            OP_WRITE: phase_sda = (bitn != BIT_ACK) && !msb;
            OP_READ_ACK: phase_sda = (bitn == BIT_ACK);
            default: phase_sda = 1'b0;
        endcase
    endfunction : phase_sda

    // --------------------
    // step sequencing
    // --------------------
    assign is_byte = (op_r == OP_WRITE) || (op_r == OP_READ_ACK) ||
                     (op_r == OP_READ_NACK);

    always_comb begin
        busy_nxt = busy_r;
        op_nxt = op_r;
        q_nxt = q_r;
        bit_nxt = bit_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        nack_nxt = nack_r;
        scl_nxt = scl_r;
        sda_low_nxt = sda_low_r;
        done_nxt = 1'b0;
        if (!busy_r) begin
            if (op_port.go) begin
                busy_nxt = 1'b1;
                op_nxt = op_port.op;
                q_nxt = 2'h0;
                bit_nxt = 4'h0;
                cnt_nxt = 8'h00;
                sh_nxt = op_port.tx_byte;
                nack_nxt = 1'b0;
            end
        end else begin
            scl_nxt = phase_scl(op_r, q_r); // see R18
            // during byte steps, data changes only while scl is low
            if (!is_byte || q_r == 2'h0) begin
                sda_low_nxt = phase_sda(op_r, q_r, bit_r, sh_r[7]);
            end
            if (cnt_r < op_port.delay) begin
                cnt_nxt = cnt_r + 8'h01;
            end else begin
                cnt_nxt = 8'h00;
                q_nxt = q_r + 2'h1;
                if (q_r == Q_SAMPLE && is_byte) begin
                    if (bit_r != BIT_ACK) begin
                        sh_nxt = {sh_r[6:0], sda_s_r}; // see R16
                    end else begin
                        nack_nxt = sda_s_r;
                    end
                end
                if (q_r == Q_LAST) begin
                    if (!is_byte || bit_r == BIT_ACK) begin
                        busy_nxt = 1'b0;
                        done_nxt = 1'b1;
                    end else begin
                        bit_nxt = bit_r + 4'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_r <= 1'b0;
            op_r <= OP_NONE;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            cnt_r <= 8'h00;
            sh_r <= 8'h00;
            nack_r <= 1'b0;
            done_r <= 1'b0;
            scl_r <= 1'b1;
            sda_low_r <= 1'b0;
            sda_meta_r <= 1'b1;
            sda_s_r <= 1'b1;
        end else if (ce_in) begin
            busy_r <= busy_nxt;
            op_r <= op_nxt;
            q_r <= q_nxt;
            bit_r <= bit_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            nack_r <= nack_nxt;
            done_r <= done_nxt;
            scl_r <= scl_nxt;
            sda_low_r <= sda_low_nxt;
            sda_meta_r <= sda_in;
            sda_s_r <= sda_meta_r;
        end
    end

    assign op_port.done = done_r;
    assign op_port.rx_byte = sh_r;
    assign op_port.nack = nack_r;
    assign scl_out = scl_r;
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_low_r;
endmodule : i2c_bit_engine

`default_nettype wire

/* File: verilog/i2c_cmd_pkg.sv */
// constants and types shared by the command-port i2c master
`default_nettype none

package i2c_cmd_pkg;

    // --------------------
    // register map (byte addresses)
    // --------------------
    localparam logic [3:0] ADDR_REQUEST = 4'h0;
    localparam logic [3:0] ADDR_RESPONSE = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_GPO = 4'hc;

    localparam int STAT_REQ_BIT = 0;
    localparam int STAT_RESP_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_DELAY_LSB = 8;

    // --------------------
    // word layout
    // --------------------
    localparam int CODE_LSB = 24;
    localparam int BYTE1_LSB = 16;
    localparam int BYTE2_LSB = 8;
    localparam int BYTE3_LSB = 0;

    // --------------------
    // command codes and fixed answers
    // --------------------
    localparam logic [7:0] CMD_REG_WRITE = 8'h01;
    localparam logic [7:0] CMD_REG_READ = 8'h02;
    localparam logic [7:0] CMD_DELAY = 8'h08;
    localparam logic [7:0] CMD_START = 8'h10;
    localparam logic [7:0] CMD_STOP = 8'h11;
    localparam logic [7:0] CMD_WRITE_BYTE = 8'h12;
    localparam logic [7:0] CMD_WRITE_LAST = 8'h13;
    localparam logic [7:0] CMD_READ_BYTE = 8'h14;
    localparam logic [7:0] CMD_READ_LAST = 8'h15;

    localparam logic [31:0] RESP_UNKNOWN = 32'hdeadbeef;
    localparam logic [31:0] RESP_BUS_ERROR = 32'hdeadcafe;

    // --------------------
    // reset values and bit timing
    // --------------------
    localparam logic [7:0] DELAY_RESET = 8'h18;
    localparam logic [7:0] GPO_RESET = 8'h00;
    localparam logic [1:0] Q_SAMPLE = 2'h2;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_START,
        OP_STOP,
        OP_WRITE,
        OP_READ_ACK,
        OP_READ_NACK
    } i2c_op_e;

endpackage : i2c_cmd_pkg

`default_nettype wire

/* File: verilog/i2c_command_port_master.sv */
// command-port i2c master: avalon slave, command sequencer, gpo
//
// Operation
// R1: request and response queues, 32 bits wide
// R2: exactly one response per taken request
// R3: host packs code and three parameter bytes
// R4: decode the nine command codes
// R5: unknown code answers 0xdeadbeef
// R6: bus error answers 0xdeadcafe
// R7: success echoes code over three result bytes
// R8: register write: start, addr, index, value, stop
// R9: register read: repeated start, read, stop
// R10: register read returns read byte low
// R11: delay command loads bus timing delay
// R12: start command, zero result bytes
// R13: stop command, zero result bytes
// R14: byte write echoes byte
// R15: last byte write then stop
// R16: acknowledged read returns byte high
// R17: unacknowledged read, then stop
// R18: scl is a plain push-pull output
// R19: eight-bit general output, read back
// R20: one command at a time, in order
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module i2c_command_port_master (
    // clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // avalon-mm slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // i2c pins
    output logic scl_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // general output
    output logic [7:0] general_output_byte_out
);
    import i2c_cmd_pkg::*;

    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_ISSUE,
        SQ_WAIT,
        SQ_RESP
    } seq_state_e;

    i2c_op_if op_port ();

    logic req_valid, resp_valid;
    logic [31:0] req_data, resp_data;
    logic req_push, req_pop, resp_push, resp_pop;
    logic [31:0] resp_word;

    seq_state_e state_r, state_nxt;
    logic [31:0] cmd_r, cmd_nxt;
    logic [2:0] step_r, step_nxt;
    i2c_op_e op_r, op_nxt;
    logic err_r, err_nxt;
    logic stopped_r, stopped_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [7:0] delay_r, delay_nxt;
    logic go;
    i2c_op_e cur_op;
    logic [7:0] code;

    logic rd_ack_r, rd_ack_nxt;
    logic rd_pop_r, rd_pop_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] gpo_r, gpo_nxt;
    logic rd_first;

    // --------------------
    // command helpers
    // --------------------
    function automatic logic [7:0] field(input logic [31:0] w,
                                         input int lsb);
        field = w[lsb +: 8];
    endfunction : field

    function automatic i2c_op_e seq_op(input logic [7:0] c,
                                       input logic [2:0] s);
        seq_op = OP_NONE;
        case (c)
            CMD_REG_WRITE: begin // see R8
                if (s == 3'h0) seq_op = OP_START;
                else if (s < 3'h4) seq_op = OP_WRITE;
                else if (s == 3'h4) seq_op = OP_STOP;
            end
            CMD_REG_READ: begin // see R9
                if (s == 3'h0 || s == 3'h3) seq_op = OP_START;
                else if (s < 3'h5) seq_op = OP_WRITE;
                else if (s == 3'h5) seq_op = OP_READ_NACK;
                else if (s == 3'h6) seq_op = OP_STOP;
            end
            CMD_START: if (s == 3'h0) seq_op = OP_START; // see R12
            CMD_STOP: if (s == 3'h0) seq_op = OP_STOP; // see R13
            CMD_WRITE_BYTE: if (s == 3'h0) seq_op = OP_WRITE; // see R14
            CMD_WRITE_LAST: begin // see R15
                if (s == 3'h0) seq_op = OP_WRITE;
                else if (s == 3'h1) seq_op = OP_STOP;
            end
            CMD_READ_BYTE: if (s == 3'h0) seq_op = OP_READ_ACK; // see R16
            CMD_READ_LAST: begin // see R17
                if (s == 3'h0) seq_op = OP_READ_NACK;
                else if (s == 3'h1) seq_op = OP_STOP;
            end
            default: seq_op = OP_NONE;
        endcase
    endfunction : seq_op

    function automatic logic [7:0] seq_byte(input logic [31:0] w,
                                            input logic [2:0] s);
        logic [7:0] c;
        logic [7:0] dev;
        c = field(w, CODE_LSB);
        dev = field(w, BYTE1_LSB);
        seq_byte = dev;
        if (c == CMD_REG_WRITE || c == CMD_REG_READ) begin
            if (s == 3'h1) seq_byte = {dev[7:1], 1'b0};
            else if (s == 3'h2) seq_byte = field(w, BYTE2_LSB);
            else if (s == 3'h3) seq_byte = field(w, BYTE3_LSB);
            else seq_byte = {dev[7:1], 1'b1};
        end
    endfunction : seq_byte

    function automatic logic [31:0] build_resp(input logic [31:0] w,
                                               input logic [7:0] rx,
                                               input logic err);
        logic [7:0] c;
        c = field(w, CODE_LSB);
        case (c) // see R7
            CMD_REG_WRITE: build_resp = w;
            CMD_REG_READ: build_resp = {w[31:8], rx}; // see R10
            CMD_DELAY, CMD_WRITE_BYTE, CMD_WRITE_LAST:
                build_resp = {w[31:16], 16'h0000}; // see R11
            CMD_START, CMD_STOP: build_resp = {c, 24'h000000};
            CMD_READ_BYTE, CMD_READ_LAST:
                build_resp = {c, rx, 16'h0000};
            default: build_resp = RESP_UNKNOWN; // see R5
        endcase
        if (err) build_resp = RESP_BUS_ERROR; // see R6
    endfunction : build_resp

    // --------------------
    // queues
    // --------------------
    word_slot u_request ( // see R1
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .push_in(req_push),
        .data_in(avs_writedata_in),
        .pop_in(req_pop),
        .valid_out(req_valid),
        .data_out(req_data)
    );

    word_slot u_response (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .push_in(resp_push),
        .data_in(resp_word),
        .pop_in(resp_pop),
        .valid_out(resp_valid),
        .data_out(resp_data)
    );

    // --------------------
    // command sequencer
    // --------------------
    assign code = field(cmd_r, CODE_LSB);
    assign cur_op = err_r ? (stopped_r ? OP_NONE : OP_STOP)
                          : seq_op(code, step_r);
    assign resp_word = build_resp(cmd_r, rx_r, err_r);

    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        step_nxt = step_r;
        op_nxt = op_r;
        err_nxt = err_r;
        stopped_nxt = stopped_r;
        rx_nxt = rx_r;
        delay_nxt = delay_r;
        go = 1'b0;
        req_pop = 1'b0;
        resp_push = 1'b0;
        case (state_r)
            SQ_IDLE: begin
                // a new request waits for the previous answer to drain
                if (req_valid && !resp_valid) begin // see R20
                    req_pop = 1'b1;
                    cmd_nxt = req_data;
                    step_nxt = 3'h0;
                    err_nxt = 1'b0;
                    stopped_nxt = 1'b0;
                    if (field(req_data, CODE_LSB) == CMD_DELAY) begin
                        delay_nxt = field(req_data, BYTE1_LSB); // see R11
                    end
                    state_nxt = SQ_ISSUE;
                end
            end
            SQ_ISSUE: begin
                if (cur_op == OP_NONE) begin
                    state_nxt = SQ_RESP;
                end else begin
                    go = 1'b1; // see R4
                    op_nxt = cur_op;
                    state_nxt = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                if (op_port.done) begin
                    step_nxt = step_r + 3'h1;
                    if (err_r) begin
                        stopped_nxt = 1'b1;
                    end else if (op_r == OP_WRITE && op_port.nack) begin
                        err_nxt = 1'b1; // see R6
                    end
                    if (op_r == OP_READ_ACK || op_r == OP_READ_NACK) begin
                        rx_nxt = op_port.rx_byte;
                    end
                    state_nxt = SQ_ISSUE;
                end
            end
            SQ_RESP: begin
                resp_push = 1'b1; // see R2
                state_nxt = SQ_IDLE;
            end
            default: state_nxt = SQ_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= SQ_IDLE;
            cmd_r <= 32'h00000000;
            step_r <= 3'h0;
            op_r <= OP_NONE;
            err_r <= 1'b0;
            stopped_r <= 1'b0;
            rx_r <= 8'h00;
            delay_r <= DELAY_RESET;
        end else if (ce_in) begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            step_r <= step_nxt;
            op_r <= op_nxt;
            err_r <= err_nxt;
            stopped_r <= stopped_nxt;
            rx_r <= rx_nxt;
            delay_r <= delay_nxt;
        end
    end

    assign op_port.go = go;
    assign op_port.op = cur_op;
    assign op_port.tx_byte = seq_byte(cmd_r, step_r);
    assign op_port.delay = delay_r;

    i2c_bit_engine u_engine (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .op_port(op_port),
        .scl_out(scl_out),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out)
    );

    // --------------------
    // avalon slave
    // --------------------
    assign rd_first = avs_read_in && !rd_ack_r;
    assign req_push = ce_in && avs_write_in &&
                      avs_address_in == ADDR_REQUEST && !req_valid;
    assign resp_pop = avs_read_in && rd_ack_r && rd_pop_r;
    assign avs_waitrequest_out = !ce_in || rd_first ||
        (avs_write_in && avs_address_in == ADDR_REQUEST && req_valid);

    always_comb begin
        rd_ack_nxt = rd_first;
        rd_pop_nxt = 1'b0;
        rdata_nxt = rdata_r;
        gpo_nxt = gpo_r;
        if (rd_first) begin
            rdata_nxt = 32'h00000000;
            if (avs_address_in == ADDR_RESPONSE) begin
                rdata_nxt = resp_valid ? resp_data : 32'h00000000;
                rd_pop_nxt = resp_valid;
            end else if (avs_address_in == ADDR_STATUS) begin
                rdata_nxt[STAT_REQ_BIT] = req_valid;
                rdata_nxt[STAT_RESP_BIT] = resp_valid;
                rdata_nxt[STAT_BUSY_BIT] = (state_r != SQ_IDLE);
                rdata_nxt[STAT_DELAY_LSB +: 8] = delay_r;
            end else if (avs_address_in == ADDR_GPO) begin
                rdata_nxt = {24'h000000, gpo_r}; // see R19
            end
        end
        if (avs_write_in && avs_address_in == ADDR_GPO &&
            avs_byteenable_in[0]) begin
            gpo_nxt = avs_writedata_in[7:0]; // see R19
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_ack_r <= 1'b0;
            rd_pop_r <= 1'b0;
            rdata_r <= 32'h00000000;
            gpo_r <= GPO_RESET;
        end else if (ce_in) begin
            rd_ack_r <= rd_ack_nxt;
            rd_pop_r <= rd_pop_nxt;
            rdata_r <= rdata_nxt;
            gpo_r <= gpo_nxt;
        end
    end

    assign avs_readdata_out = rdata_r;
    assign general_output_byte_out = gpo_r;
endmodule : i2c_command_port_master

`default_nettype wire

/* File: verilog/i2c_op_if.sv */
// bus-step request and answer between sequencer and bit engine
`timescale 1ns/100ps
`default_nettype none

interface i2c_op_if;
    import i2c_cmd_pkg::*;
    logic go;
    i2c_op_e op;
    logic [7:0] tx_byte;
    logic [7:0] delay;
    logic done;
    logic [7:0] rx_byte;
    logic nack;

    modport seq (output go, op, tx_byte, delay,
                 input done, rx_byte, nack);
    modport engine (input go, op, tx_byte, delay,
                    output done, rx_byte, nack);
endinterface : i2c_op_if

`default_nettype wire

/* File: verilog/word_slot.sv */
// one-word queue stage with push, pop and valid flag
`timescale 1ns/100ps
`default_nettype none

module word_slot (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // fill side
    input wire logic push_in,
    input wire logic [31:0] data_in,
    // drain side
    input wire logic pop_in,
    output logic valid_out,
    output logic [31:0] data_out
);
    logic valid_r, valid_nxt;
    logic [31:0] data_r, data_nxt;

    always_comb begin
        valid_nxt = valid_r;
        data_nxt = data_r;
        if (pop_in) begin
            valid_nxt = 1'b0;
        end
        if (push_in && !valid_r) begin
            valid_nxt = 1'b1;
            data_nxt = data_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_r <= 1'b0;
            data_r <= 32'h00000000;
        end else if (ce_in) begin
            valid_r <= valid_nxt;
            data_r <= data_nxt;
        end
    end

    assign valid_out = valid_r;
    assign data_out = data_r;
endmodule : word_slot

`default_nettype wire
